// ### core/dma_two_channel.sv
// How it works
// R1 - Two channels, each taking requests from its pin, a serial port or timer 2.
// R2 - Memory or I/O on each side; byte or word at any address.
// R3 - Each transfer is one source read then one destination write.
// R4 - Read and write are locked together; nothing enters between them.
// R5 - Control bit 15 puts the destination in memory when 1, I/O when 0.
// R6 - Control bit 14 steps the destination address down by 1 or 2.
// R7 - Control bit 13 steps the destination address up by 1 or 2.
// R8 - Destination up and down both set keeps its address fixed.
// R9 - Control bit 12 puts the source in memory when 1, I/O when 0.
// R10 - Bit 11 steps the source down, bit 10 up, by 1 or 2.
// R11 - Source up and down equal keeps the source address fixed.
// R12 - Synchronized runs stop at zero count only when bit 9 is set.
// R13 - Unsynchronized runs always stop when the count reaches zero.
// R14 - Bit 8 raises an interrupt at count end, only with bit 9 set.
// R15 - Bits 7-6: none, source or destination handshake; 11 is reserved.
// R16 - With both channels requesting, the channel with bit 5 set goes first.
// R17 - Bit 4 lets timer 2 overflow request transfers for the channel.
// R18 - Software sets bit 2 in any write meant to change the run flag.
// R19 - A control write with bit 2 clear keeps the run flag as it was.
// R20 - Bit 1 written 1 starts the channel, written 0 stops it.
// R21 - Bit 0 selects word steps of 2 when set, byte steps of 1 when clear.
// R22 - Each completed transfer lowers the 16-bit count by one.
// R23 - Requests are sampled and must stand four clocks before a transfer.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module dma_two_channel
  import dma_pkg::*;
#(
  parameter int REQ_DELAY = REQ_DELAY_CLKS,
  parameter int DEST_GAP  = DEST_GAP_CLKS
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_ext_request_ch0,
  input  wire logic        i_ext_request_ch1,
  input  wire logic [1:0]  i_serial_request,
  input  wire logic        i_timer2_overflow,
  output logic             o_bus_req,
  output logic             o_bus_write,
  output logic             o_bus_lock,
  output logic             o_bus_mem,
  output logic             o_bus_word,
  output logic      [19:0] o_bus_addr,
  output logic      [15:0] o_bus_wdata,
  input  wire logic [15:0] i_bus_rdata,
  input  wire logic        i_bus_ack,
  output logic      [1:0]  o_done_irq
);
  logic [15:0] ctrl_q [NUM_CH];
  logic [15:0] count_q [NUM_CH];
  logic [19:0] src_q [NUM_CH];
  logic [19:0] dst_q [NUM_CH];
  logic [1:0]  req_select_q;
  logic [1:0]  timer_pend_q;
  logic [1:0]  irq_q;
  logic [15:0] data_q;
  logic [19:0] addr_q;
  logic        mem_q;
  logic [3:0]  gap_q;
  logic        ch_q;
  xfer_state_t state_q;

  logic        apb_wr;
  logic        apb_hit;
  logic        apb_ch;
  logic [7:0]  apb_idx;
  logic [7:0]  apb_reg;
  logic [15:0] rd_val;
  logic [1:0]  raw_req;
  logic [1:0]  qual_ok;
  logic [1:0]  eligible;
  logic [1:0]  taken;
  logic        grant_valid;
  logic        grant_ch;
  logic        done;
  logic [15:0] count_next;
  logic        terminate;

  function automatic logic [19:0] step_addr(input logic [19:0] a, input logic up,
                                            input logic dn, input logic word);
    logic [19:0] step;
    step = word ? STEP_WORD : STEP_BYTE;  // see R21
    if (up && !dn) begin
      step_addr = a + step;  // see R7
    end else if (dn && !up) begin
      step_addr = a - step;  // see R6
    end else begin
      step_addr = a;  // see R8
    end
  endfunction : step_addr

  function automatic logic [1:0] handshake_of(input logic [15:0] c);
    handshake_of = c[HANDSHAKE_HI:HANDSHAKE_LO];
  endfunction : handshake_of

  // APB slave: no wait states, unmapped indices answer with an error
  assign apb_idx = i_paddr[9:2];
  assign apb_ch  = (apb_idx >= IDX_SRC_LO_CH0 + IDX_CH1_STRIDE) && (apb_idx != IDX_REQ_SELECT);
  assign apb_reg = apb_ch ? apb_idx - IDX_CH1_STRIDE : apb_idx;
  assign apb_hit = (i_paddr[11:10] == 2'h0) && ((apb_idx == IDX_REQ_SELECT)
                   || (apb_reg >= IDX_SRC_LO_CH0 && apb_reg <= IDX_CTRL_CH0 && !apb_reg[0]));
  assign apb_wr    = i_psel && i_penable && i_pwrite && apb_hit;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !apb_hit;

  always_comb begin
    rd_val = 16'h0000;
    if (apb_idx == IDX_REQ_SELECT) begin
      rd_val = {14'h0000, req_select_q};
    end else begin
      case (apb_reg)
        IDX_SRC_LO_CH0: rd_val = src_q[apb_ch][15:0];
        IDX_SRC_HI_CH0: rd_val = {12'h000, src_q[apb_ch][19:16]};
        IDX_DST_LO_CH0: rd_val = dst_q[apb_ch][15:0];
        IDX_DST_HI_CH0: rd_val = {12'h000, dst_q[apb_ch][19:16]};
        IDX_COUNT_CH0:  rd_val = count_q[apb_ch];
        IDX_CTRL_CH0:   rd_val = ctrl_q[apb_ch];
        default:        rd_val = 16'h0000;
      endcase
    end
    o_prdata = {16'h0000, rd_val};
  end

  // Request sources per channel
  assign raw_req[0] = (req_select_q[0] ? i_serial_request[0] : i_ext_request_ch0)
                      || timer_pend_q[0];  // see R1
  assign raw_req[1] = (req_select_q[1] ? i_serial_request[1] : i_ext_request_ch1)
                      || timer_pend_q[1];  // see R1

  for (genvar c = 0; c < NUM_CH; c++) begin : g_qual
    dma_req_qualify #(
      .DELAY_CLKS (REQ_DELAY)
    ) u_qual (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_request (raw_req[c]),
      .i_taken   (taken[c]),
      .o_ready   (qual_ok[c])
    );  // see R23

    // Handshake modes and timer pacing wait for a qualified request
    assign eligible[c] = ctrl_q[c][RUN_FLAG] && handshake_of(ctrl_q[c]) != HANDSHAKE_RSVD
                         && ((handshake_of(ctrl_q[c]) == HANDSHAKE_NONE
                              && !ctrl_q[c][TIMER_REQUEST_ENABLE]) || qual_ok[c]);  // see R15
    assign taken[c] = grant_valid && (grant_ch == c);
  end

  assign grant_valid = (state_q == PH_IDLE) && |eligible;
  assign grant_ch    = (&eligible) ? (ctrl_q[1][PRIORITY_HIGH] && !ctrl_q[0][PRIORITY_HIGH])
                                   : eligible[1];  // see R16

  assign done       = (state_q == PH_WRITE) && i_bus_ack;
  assign count_next = count_q[ch_q] - 16'h0001;  // see R22
  assign terminate  = (count_next == 16'h0000)
                      && (handshake_of(ctrl_q[ch_q]) == HANDSHAKE_NONE  // see R13
                          || ctrl_q[ch_q][STOP_AT_ZERO_COUNT]);  // see R12

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      timer_pend_q <= 2'h0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (i_timer2_overflow && ctrl_q[c][TIMER_REQUEST_ENABLE]) begin
          timer_pend_q[c] <= 1'b1;  // see R17
        end else if (taken[c]) begin
          timer_pend_q[c] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      req_select_q <= 2'h0;
    end else if (apb_wr && apb_idx == IDX_REQ_SELECT) begin
      req_select_q <= i_pwdata[1:0];
    end
  end

  // Control: software writes win over the hardware stop in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ctrl_q[c] <= CTRL_RESET;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (apb_wr && apb_ch == c && apb_reg == IDX_CTRL_CH0 && apb_idx != IDX_REQ_SELECT) begin
          ctrl_q[c] <= (i_pwdata[15:0] & CTRL_STORE_MASK) | (ctrl_q[c] & ~CTRL_STORE_MASK);
          if (i_pwdata[RUN_WRITE_QUALIFIER]) begin
            ctrl_q[c][RUN_FLAG] <= i_pwdata[RUN_FLAG];  // see R20
          end  // see R19
        end else if (done && ch_q == c && terminate) begin
          ctrl_q[c][RUN_FLAG] <= 1'b0;  // see R12
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        count_q[c] <= 16'h0000;
        src_q[c]   <= 20'h00000;
        dst_q[c]   <= 20'h00000;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (apb_wr && apb_ch == c && apb_idx != IDX_REQ_SELECT) begin
          case (apb_reg)
            IDX_SRC_LO_CH0: src_q[c][15:0]  <= i_pwdata[15:0];
            IDX_SRC_HI_CH0: src_q[c][19:16] <= i_pwdata[3:0] & ADDR_HI_MASK;
            IDX_DST_LO_CH0: dst_q[c][15:0]  <= i_pwdata[15:0];
            IDX_DST_HI_CH0: dst_q[c][19:16] <= i_pwdata[3:0] & ADDR_HI_MASK;
            IDX_COUNT_CH0:  count_q[c]      <= i_pwdata[15:0];
            default:        count_q[c]      <= count_q[c];
          endcase
        end else if (done && ch_q == c) begin
          count_q[c] <= count_next;  // see R22
          src_q[c] <= step_addr(src_q[c], ctrl_q[c][SOURCE_UP_STEP], ctrl_q[c][SOURCE_DOWN_STEP],
                                ctrl_q[c][WORD_SELECT]);  // see R10, R11
          dst_q[c] <= step_addr(dst_q[c], ctrl_q[c][DEST_UP_STEP], ctrl_q[c][DEST_DOWN_STEP],
                                ctrl_q[c][WORD_SELECT]);  // see R6, R7, R8
        end
      end
    end
  end

  // Transfer sequencer: read then locked write, then an optional gap
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      state_q <= PH_IDLE;
      ch_q    <= 1'b0;
      addr_q  <= 20'h00000;
      mem_q   <= 1'b0;
      data_q  <= 16'h0000;
      gap_q   <= 4'h0;
    end else begin
      case (state_q)
        PH_IDLE: begin
          if (grant_valid) begin
            ch_q    <= grant_ch;
            addr_q  <= src_q[grant_ch];
            mem_q   <= ctrl_q[grant_ch][SOURCE_SPACE_SELECT];  // see R9
            state_q <= PH_READ;  // see R3
          end
        end
        PH_READ: begin
          if (i_bus_ack) begin
            data_q  <= i_bus_rdata;
            addr_q  <= dst_q[ch_q];
            mem_q   <= ctrl_q[ch_q][DEST_SPACE_SELECT];  // see R5
            state_q <= PH_WRITE;  // see R4
          end
        end
        PH_WRITE: begin
          if (i_bus_ack) begin
            if (handshake_of(ctrl_q[ch_q]) == HANDSHAKE_DEST) begin
              gap_q   <= 4'(DEST_GAP - 1);
              state_q <= PH_GAP;
            end else begin
              state_q <= PH_IDLE;
            end
          end
        end
        PH_GAP: begin
          if (gap_q == 4'h0) begin
            state_q <= PH_IDLE;
          end else begin
            gap_q <= gap_q - 4'h1;
          end
        end
        default: state_q <= PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      irq_q <= 2'h0;
    end else begin
      irq_q <= 2'h0;
      if (done && terminate && ctrl_q[ch_q][IRQ_ENABLE] && ctrl_q[ch_q][STOP_AT_ZERO_COUNT]) begin
        irq_q[ch_q] <= 1'b1;  // see R14
      end
    end
  end

  assign o_bus_req   = (state_q == PH_READ) || (state_q == PH_WRITE);
  assign o_bus_write = (state_q == PH_WRITE);
  assign o_bus_lock  = o_bus_req;  // see R4
  assign o_bus_mem   = mem_q;
  assign o_bus_word  = ctrl_q[ch_q][WORD_SELECT];  // see R2
  assign o_bus_addr  = addr_q;
  assign o_bus_wdata = data_q;
  assign o_done_irq  = irq_q;

  property p_read_then_write;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (o_bus_req && !o_bus_write && i_bus_ack) |=> (o_bus_req && o_bus_write && o_bus_lock);
  endproperty
  a_read_then_write: assert property (p_read_then_write) else $error("write did not follow read");  // see R3

  property p_locked_pair;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      $rose(o_bus_req) |-> !o_bus_write && o_bus_lock && $past(grant_valid);
  endproperty
  a_locked_pair: assert property (p_locked_pair) else $error("transfer did not open with a locked read");  // see R4

  property p_dest_space;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (o_bus_write && o_bus_req) |-> o_bus_mem == ctrl_q[ch_q][DEST_SPACE_SELECT];
  endproperty
  a_dest_space: assert property (p_dest_space) else $error("destination space wrong");  // see R5

  property p_source_space;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (o_bus_req && !o_bus_write) |-> o_bus_mem == ctrl_q[ch_q][SOURCE_SPACE_SELECT];
  endproperty
  a_source_space: assert property (p_source_space) else $error("source space wrong");  // see R9

  property p_count_down;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (done && !apb_wr) |=> count_q[$past(ch_q)] == $past(count_q[ch_q]) - 16'h0001;
  endproperty
  a_count_down: assert property (p_count_down) else $error("count did not drop by one");  // see R22

  property p_dest_fixed;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (done && !apb_wr && ctrl_q[ch_q][DEST_UP_STEP] && ctrl_q[ch_q][DEST_DOWN_STEP])
      |=> dst_q[$past(ch_q)] == $past(dst_q[ch_q]);
  endproperty
  a_dest_fixed: assert property (p_dest_fixed) else $error("destination moved");  // see R8

  property p_run_kept;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (apb_wr && apb_reg == IDX_CTRL_CH0 && apb_idx != IDX_REQ_SELECT
       && !i_pwdata[RUN_WRITE_QUALIFIER] && !done)
      |=> ctrl_q[$past(apb_ch)][RUN_FLAG] == $past(ctrl_q[apb_ch][RUN_FLAG]);
  endproperty
  a_run_kept: assert property (p_run_kept) else $error("run flag changed without qualifier");  // see R19

  property p_irq_cause;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (|o_done_irq) |-> $past(done) && $past(ctrl_q[ch_q][STOP_AT_ZERO_COUNT])
                        && $past(ctrl_q[ch_q][IRQ_ENABLE]) && count_q[ch_q] == 16'h0000;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");  // see R14

  property p_unsync_stop;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (done && !apb_wr && count_next == 16'h0000 && handshake_of(ctrl_q[ch_q]) == HANDSHAKE_NONE)
      |=> !ctrl_q[$past(ch_q)][RUN_FLAG] && !taken[$past(ch_q)];
  endproperty
  a_unsync_stop: assert property (p_unsync_stop) else $error("channel ran past zero");  // see R13

  property p_priority;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (grant_valid && &eligible && ctrl_q[1][PRIORITY_HIGH] && !ctrl_q[0][PRIORITY_HIGH])
      |=> ch_q == 1'b1;
  endproperty
  a_priority: assert property (p_priority) else $error("low priority channel served first");  // see R16
endmodule : dma_two_channel
`default_nettype wire

// ### core/dma_pkg.sv
`default_nettype none
package dma_pkg;
  localparam int NUM_CH = 2;

  // Register indices; the APB byte address is four times the index
  localparam logic [7:0] IDX_SRC_LO_CH0 = 8'hC0;
  localparam logic [7:0] IDX_SRC_HI_CH0 = 8'hC2;
  localparam logic [7:0] IDX_DST_LO_CH0 = 8'hC4;
  localparam logic [7:0] IDX_DST_HI_CH0 = 8'hC6;
  localparam logic [7:0] IDX_COUNT_CH0  = 8'hC8;
  localparam logic [7:0] IDX_CTRL_CH0   = 8'hCA;
  localparam logic [7:0] IDX_CH1_STRIDE = 8'h10;
  localparam logic [7:0] IDX_REQ_SELECT = 8'hE0;

  // Control register fields
  localparam int DEST_SPACE_SELECT    = 15;
  localparam int DEST_DOWN_STEP       = 14;
  localparam int DEST_UP_STEP         = 13;
  localparam int SOURCE_SPACE_SELECT  = 12;
  localparam int SOURCE_DOWN_STEP     = 11;
  localparam int SOURCE_UP_STEP       = 10;
  localparam int STOP_AT_ZERO_COUNT   = 9;
  localparam int IRQ_ENABLE           = 8;
  localparam int HANDSHAKE_HI         = 7;
  localparam int HANDSHAKE_LO         = 6;
  localparam int PRIORITY_HIGH        = 5;
  localparam int TIMER_REQUEST_ENABLE = 4;
  localparam int RUN_WRITE_QUALIFIER  = 2;
  localparam int RUN_FLAG             = 1;
  localparam int WORD_SELECT          = 0;

  localparam logic [15:0] CTRL_RESET      = 16'hFFF9;
  localparam logic [15:0] CTRL_STORE_MASK = 16'hFFF5;
  localparam logic [3:0]  ADDR_HI_MASK    = 4'hF;

  localparam logic [1:0] HANDSHAKE_NONE   = 2'h0;
  localparam logic [1:0] HANDSHAKE_SOURCE = 2'h1;
  localparam logic [1:0] HANDSHAKE_DEST   = 2'h2;
  localparam logic [1:0] HANDSHAKE_RSVD   = 2'h3;

  localparam logic [19:0] STEP_BYTE = 20'h00001;
  localparam logic [19:0] STEP_WORD = 20'h00002;

  localparam int REQ_DELAY_CLKS = 4;
  localparam int DEST_GAP_CLKS  = 2;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_READ,
    PH_WRITE,
    PH_GAP
  } xfer_state_t;
endpackage : dma_pkg
`default_nettype wire

// ### core/dma_req_qualify.sv
`timescale 1ns/1ns
`default_nettype none
module dma_req_qualify
  import dma_pkg::*;
#(
  parameter int DELAY_CLKS = REQ_DELAY_CLKS
) (
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  input  wire logic i_request,
  input  wire logic i_taken,
  output logic      o_ready
);
  logic       sampled_q;
  logic [3:0] age_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      sampled_q <= 1'b0;
    end else begin
      sampled_q <= i_request;
    end
  end

  // A request must stand for the full delay before it may start a transfer
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n || i_taken || !sampled_q) begin
      age_q <= 4'h0;
    end else if (age_q < 4'(DELAY_CLKS)) begin
      age_q <= age_q + 4'h1;
    end
  end

  assign o_ready = sampled_q && (age_q >= 4'(DELAY_CLKS - 1));
endmodule : dma_req_qualify
`default_nettype wire

// ### sim/bus_partner_model.sv
`timescale 1ns/1ns
`default_nettype none
module bus_partner_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_bus_req,
  input  wire logic        i_bus_write,
  input  wire logic [19:0] i_bus_addr,
  input  wire logic        i_slow,
  output logic             o_bus_ack,
  output logic      [15:0] o_bus_rdata,
  output logic             o_split
);
  logic [2:0]  wait_q;
  logic        rd_done_q;
  logic [15:0] junk_q;

  // Read data is valid only in the acknowledge cycle; otherwise the lines churn
  assign o_bus_rdata = (o_bus_ack && !i_bus_write) ? (i_bus_addr[15:0] ^ 16'h5AC3) : junk_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_bus_ack <= 1'b0;
      wait_q    <= 3'h0;
    end else if (i_bus_req && !o_bus_ack && wait_q >= (i_slow ? 3'h3 : 3'h0)) begin
      o_bus_ack <= 1'b1;
      wait_q    <= 3'h0;
    end else begin
      o_bus_ack <= 1'b0;
      wait_q    <= (i_bus_req && !o_bus_ack) ? wait_q + 3'h1 : 3'h0;
    end
  end

  // Flags a write phase that does not follow its read at once
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      junk_q    <= 16'hC35A;
      rd_done_q <= 1'b0;
      o_split   <= 1'b0;
    end else begin
      junk_q    <= ~junk_q;
      rd_done_q <= i_bus_req && o_bus_ack && !i_bus_write;
      if (rd_done_q && !(i_bus_req && i_bus_write)) begin
        o_split <= 1'b1;
      end
    end
  end
endmodule : bus_partner_model
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dma_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr;
  logic        req0 = 1'b0, req1 = 1'b0, tmr = 1'b0, slow = 1'b0;
  logic [1:0]  ser = 2'b00, done_irq;
  logic        bus_req, bus_write, bus_lock, bus_mem, bus_word, bus_ack, split, req_q = 1'b0;
  logic [19:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata, wd_last;
  logic        wm_last, ww_last, rd_mem;
  logic [31:0] seed = 32'heb733b43;
  logic [19:0] wq[$];
  int          rise_q[$];
  int          cyc = 0, irq_n0 = 0, irq_n1 = 0, bad_count = 0, n_compared = 0;
  logic        lock_ok = 1'b1;

  always #5 clk = ~clk;

  dma_two_channel i_dut (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ext_request_ch0(req0),
    .i_ext_request_ch1(req1), .i_serial_request(ser), .i_timer2_overflow(tmr),
    .o_bus_req(bus_req), .o_bus_write(bus_write), .o_bus_lock(bus_lock), .o_bus_mem(bus_mem),
    .o_bus_word(bus_word), .o_bus_addr(bus_addr), .o_bus_wdata(bus_wdata),
    .i_bus_rdata(bus_rdata), .i_bus_ack(bus_ack), .o_done_irq(done_irq)
  );

  bus_partner_model i_mem (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_bus_req(bus_req), .i_bus_write(bus_write),
    .i_bus_addr(bus_addr), .i_slow(slow), .o_bus_ack(bus_ack), .o_bus_rdata(bus_rdata),
    .o_split(split)
  );

  // Records every bus phase as the design drives it
  always @(posedge clk) begin
    cyc    <= cyc + 1;
    req_q  <= bus_req;
    irq_n0 <= irq_n0 + int'(done_irq[0]);
    irq_n1 <= irq_n1 + int'(done_irq[1]);
    if (bus_req && !bus_lock) lock_ok <= 1'b0;
    if (bus_req && !req_q) rise_q.push_back(cyc);
    if (bus_req && bus_ack && !bus_write) rd_mem <= bus_mem;
    if (bus_req && bus_ack && bus_write) begin
      wq.push_back(bus_addr);
      wd_last <= bus_wdata;
      wm_last <= bus_mem;
      ww_last <= bus_word;
    end
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic logic [19:0] step(logic [19:0] a, logic up, logic dn, logic wd, int n);
    logic [19:0] s;
    s = wd ? 20'h00002 : 20'h00001;
    if (up && !dn) return a + 20'(n) * s;
    if (dn && !up) return a - 20'(n) * s;
    return a;
  endfunction : step

  function automatic logic [31:0] ctl(logic [15:0] w, logic run);
    return {16'h0000, (w & CTRL_STORE_MASK) | 16'h0008 | {14'h0000, run, 1'b0}};
  endfunction : ctl

  task automatic close_out();
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] idx, input logic [15:0] d,
                     output logic [31:0] r, output logic e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wreg(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask : wreg

  task automatic creg(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 16'h0000, r, e);
    chk($sformatf("register %h", idx), exp, r);
  endtask : creg

  task automatic hold_pin(input int n);
    wq.delete();
    if (n > 0) begin
      req0 <= 1'b1;
      repeat (n) @(posedge clk);
      req0 <= 1'b0;
    end
    repeat (20) @(posedge clk);
  endtask : hold_pin

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    close_out();
  end

  initial begin
    logic [31:0] r, c;
    logic [19:0] s, d, s1, d1, sn, dn;
    logic [15:0] w;
    logic        e;
    int          n, base, t0, k;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    creg(IDX_CTRL_CH0, 32'h0000FFF9);
    creg(IDX_CTRL_CH0 + IDX_CH1_STRIDE, 32'h0000FFF9);
    apb(1'b0, 8'h40, 16'h0000, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    // Unsynchronized runs: random modes, corners forced in the first two
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      c = rnd();
      if (i == 0) c[14:10] = 5'b11111;
      if (i == 1) c[14:10] = 5'b00100;
      s = r[19:0];
      d = c[19:0] ^ r[31:12];
      n = 1 + int'(r[31:30]);
      w = {c[15:8], 8'h06} | {15'h0000, c[0]};
      slow <= r[29];
      wq.delete();
      wreg(IDX_SRC_LO_CH0, s[15:0]);
      wreg(IDX_SRC_HI_CH0, {12'h000, s[19:16]});
      wreg(IDX_DST_LO_CH0, d[15:0]);
      wreg(IDX_DST_HI_CH0, {12'h000, d[19:16]});
      wreg(IDX_COUNT_CH0, 16'(n));
      base = irq_n0;
      wreg(IDX_CTRL_CH0, w);
      k = 0;
      while (wq.size() < n && k < 600) begin
        @(posedge clk);
        k++;
      end
      repeat (6) @(posedge clk);
      s1 = step(s, c[10], c[11], c[0], n - 1);
      d1 = step(d, c[13], c[14], c[0], n - 1);
      sn = step(s, c[10], c[11], c[0], n);
      dn = step(d, c[13], c[14], c[0], n);
      chk("transfer count", n, wq.size());
      chk("last dest addr", {12'h000, d1}, {12'h000, wq[$]});
      chk("last data", {16'h0000, s1[15:0] ^ 16'h5AC3}, {16'h0000, wd_last});
      chk("dest space", {31'h0, c[15]}, {31'h0, wm_last});
      chk("source space", {31'h0, c[12]}, {31'h0, rd_mem});
      chk("word select", {31'h0, c[0]}, {31'h0, ww_last});
      creg(IDX_SRC_LO_CH0, {16'h0000, sn[15:0]});
      creg(IDX_SRC_HI_CH0, {28'h0000000, sn[19:16]});
      creg(IDX_DST_LO_CH0, {16'h0000, dn[15:0]});
      creg(IDX_DST_HI_CH0, {28'h0000000, dn[19:16]});
      creg(IDX_COUNT_CH0, 32'h0);
      creg(IDX_CTRL_CH0, ctl(w, 1'b0));
      chk("done irq", {31'h0, c[9] & c[8]}, irq_n0 - base);
    end
    slow <= 1'b0;
    wreg(IDX_COUNT_CH0, 16'h0002);
    wreg(IDX_CTRL_CH0, 16'h9446);
    hold_pin(0);
    repeat (30) @(posedge clk);
    chk("idle without request", 32'h0, wq.size());
    rise_q.delete();
    t0 = cyc;
    hold_pin(80);
    chk("request delay", 32'h1, {31'h0, rise_q.size() > 0 && rise_q[0] - t0 >= REQ_DELAY_CLKS
        && rise_q[0] - t0 <= REQ_DELAY_CLKS + 4});
    chk("ran past zero", 32'h1, {31'h0, wq.size() > 2});
    creg(IDX_CTRL_CH0, ctl(16'h9446, 1'b1));
    wreg(IDX_CTRL_CH0, 16'h94C0);
    creg(IDX_CTRL_CH0, ctl(16'h94C0, 1'b1));
    hold_pin(40);
    chk("reserved handshake", 32'h0, wq.size());
    wreg(IDX_CTRL_CH0, 16'h94C4);
    wreg(IDX_CTRL_CH0, 16'h9440);
    creg(IDX_CTRL_CH0, ctl(16'h9440, 1'b0));
    hold_pin(40);
    chk("stopped channel", 32'h0, wq.size());
    wreg(IDX_DST_LO_CH0, 16'h1000);
    wreg(IDX_DST_HI_CH0, 16'h0000);
    wreg(IDX_DST_LO_CH0 + IDX_CH1_STRIDE, 16'h2000);
    wreg(IDX_COUNT_CH0, 16'h0001);
    wreg(IDX_COUNT_CH0 + IDX_CH1_STRIDE, 16'h0001);
    wreg(IDX_CTRL_CH0, 16'h8016);
    wreg(IDX_CTRL_CH0 + IDX_CH1_STRIDE, 16'h8336);
    hold_pin(0);
    chk("wait for timer", 32'h0, wq.size());
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
    repeat (60) @(posedge clk);
    chk("first served", 32'h02000, {12'h000, wq[0]});
    chk("second served", 32'h01000, {12'h000, wq[1]});
    chk("ch1 done irq", 32'h1, irq_n1);
    wreg(IDX_REQ_SELECT, 16'h0001);
    wreg(IDX_CTRL_CH0, 16'h8086);
    hold_pin(10);
    chk("pin ignored", 32'h0, wq.size());
    ser <= 2'b01;
    repeat (8) @(posedge clk);
    ser <= 2'b00;
    repeat (20) @(posedge clk);
    chk("serial request", 32'h1, {31'h0, wq.size() > 0});
    chk("read write locked", 32'h0, {31'h0, split});
    chk("bus lock", 32'h1, {31'h0, lock_ok});
    close_out();
  end
endmodule : tb
`default_nettype wire
